// >>> common/mcfg_consts.svh
// Constants of the motion feature configuration block: register offsets,
// feature word layout, reset values and timing counts.
// Assumes inclusion by bare name; definitions only.
`ifndef MCFG_CONSTS_SVH
`define MCFG_CONSTS_SVH

// ---------------------------------------------------------------
// Host register offsets and reset values
// ---------------------------------------------------------------
`define MCFG_ADDR_PIN1_ROUTE  8'h56
`define MCFG_ADDR_INIT_CTRL   8'h59
`define MCFG_ADDR_FEAT_PORT   8'h5e
`define MCFG_RST_PIN1_ROUTE   8'h00
`define MCFG_RST_INIT_CTRL    8'h90
`define MCFG_RST_FEAT_PORT    8'h00
`define MCFG_BIT_ROUTE_MOTION 6

// ---------------------------------------------------------------
// Feature word layout
// ---------------------------------------------------------------
`define MCFG_NUM_WORDS        23
`define MCFG_BIT_NOMOTION     11
`define MCFG_BIT_X_EN         13
`define MCFG_BIT_Y_EN         14
`define MCFG_BIT_Z_EN         15
`define MCFG_THR_MSB          10
`define MCFG_DUR_MSB          12

// ---------------------------------------------------------------
// Sample timing: 20 ms at 200 MHz
// ---------------------------------------------------------------
`define MCFG_SAMPLE_MS        20
`define MCFG_CLK_MHZ          200
`define MCFG_SAMPLE_CYC       (`MCFG_SAMPLE_MS * 1000 * `MCFG_CLK_MHZ)

`endif

// >>> common/mcfg_pkg.sv
// Types shared by the motion feature configuration block.
// Assumes nothing of its surroundings.
package mcfg_pkg;

  // Motion detector states, one-hot
  typedef enum logic [1:0] {
    MCFG_IDLE  = 2'b01,
    MCFG_FIRED = 2'b10
  } mcfg_det_t;

endpackage : mcfg_pkg

// >>> core/mcfg_motion_det.sv
// Any-motion / no-motion detector driven by feature word settings.
// Assumes per-axis slopes arrive with a one-cycle sample strobe.
`timescale 1ns/1ps
module mcfg_motion_det #(
  parameter int SW = 11,
  parameter int DW = 13
) (
  // Clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          rst_b_i,
  input  wire logic          clk_en_i,
  // Settings
  input  wire logic [SW-1:0] thr_i,
  input  wire logic          nomotion_i,
  input  wire logic [DW-1:0] dur_i,
  input  wire logic [2:0]    axis_en_i,
  // Samples
  input  wire logic          smp_stb_i,
  input  wire logic [SW-1:0] slope_x_i,
  input  wire logic [SW-1:0] slope_y_i,
  input  wire logic [SW-1:0] slope_z_i,
  // Result
  output logic               motion_o
);

  logic [2:0]    over;
  logic          cond;
  logic [DW-1:0] cnt_r;
  logic [DW-1:0] cnt_nxt;
  mcfg_pkg::mcfg_det_t st_r;
  mcfg_pkg::mcfg_det_t st_nxt;

  // Per-axis threshold comparison, gated by axis enable
  assign over[0] = axis_en_i[0] && (slope_x_i > thr_i);
  assign over[1] = axis_en_i[1] && (slope_y_i > thr_i);
  assign over[2] = axis_en_i[2] && (slope_z_i > thr_i);
  // Mode select: any axis over, or all enabled axes quiet
  assign cond = nomotion_i ? ~|over : |over;

  // Consecutive-sample counter and event state
  always_comb begin
    cnt_nxt = cnt_r;
    st_nxt  = st_r;
    if (smp_stb_i) begin
      if (!cond || axis_en_i == 3'h0) begin
        cnt_nxt = '0;
        st_nxt  = mcfg_pkg::MCFG_IDLE;
      end else if (cnt_r >= dur_i) begin
        st_nxt = mcfg_pkg::MCFG_FIRED;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r + 1'b1 >= dur_i) begin
          st_nxt = mcfg_pkg::MCFG_FIRED;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= '0;
      st_r  <= mcfg_pkg::MCFG_IDLE;
    end else if (clk_en_i) begin
      cnt_r <= cnt_nxt;
      st_r  <= st_nxt;
    end
  end

  assign motion_o = (st_r == mcfg_pkg::MCFG_FIRED);

endmodule : mcfg_motion_det

// >>> core/mcfg_feature_cfg.sv
// Feature configuration register bank with byte-wide feature port.
// Assumes a simple byte register port decoded from the serial interface.
// Function
// - Init control register, resets 0x90; a host write starts initialization.
// - Feature port register at 0x5E, resets 0x00, reaches feature words.
// - Two motion words at offsets 0x00, 0x02 default 0x00AA, 0x0005.
// - Low field of first word is slope threshold, default 0xAA.
// - Bit 11 of first word selects no-motion (1) or any-motion (0).
// - Event asserts after condition holds for duration consecutive 20 ms samples.
// - Bits 13..15 of second word enable x, y, z axes.
// - Twenty-one step parameter words at 0x04..0x2C with tabulated defaults.
// - Bit 6 of register 0x56 routes motion output to interrupt pin one.
`timescale 1ns/1ps
`include "mcfg_consts.svh"
module mcfg_feature_cfg #(
  parameter int SAMPLE_CYC = `MCFG_SAMPLE_CYC,
  parameter int NW         = `MCFG_NUM_WORDS
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        clk_en_i,
  // Register port from the serial interface
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        burst_start_i,
  output logic [7:0]       reg_rdata_o,
  // Acceleration slopes
  input  wire logic [10:0] slope_x_i,
  input  wire logic [10:0] slope_y_i,
  input  wire logic [10:0] slope_z_i,
  // Device outputs
  output logic             init_start_o,
  output logic             motion_o,
  output logic             int1_o,
  output logic [15:0]      step_param_o [21]
);

  // ---------------------------------------------------------------
  // Reset values of the feature words
  // ---------------------------------------------------------------
  localparam logic [15:0] WORD_RST [NW] = '{
    16'h00aa, 16'h0005,
    16'h012d, 16'h7bd4, 16'h013b, 16'h7adb, 16'h0004,
    16'h7b3f, 16'h6ccd, 16'h04c3, 16'h0985, 16'h04c3,
    16'he6ec, 16'h460c, 16'h0001, 16'h0027, 16'h0019,
    16'h0096, 16'h00a0, 16'h0001, 16'h000c, 16'h3cf0,
    16'h0100
  };
  localparam int OW = $clog2(2 * NW);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [7:0]    init_r;
  logic [7:0]    init_nxt;
  logic [7:0]    route_r;
  logic [7:0]    route_nxt;
  logic [OW-1:0] off_r;
  logic [OW-1:0] off_nxt;
  logic          start_r;
  logic          start_nxt;
  logic [7:0]    rdata_r;
  logic [7:0]    rdata_nxt;
  logic [15:0]   word_r   [NW];
  logic [15:0]   word_nxt [NW];
  logic          port_hit;
  logic [4:0]    widx;
  logic [7:0]    cur_byte;

  // ---------------------------------------------------------------
  // Feature port byte addressing
  // ---------------------------------------------------------------
  // Any access to the port address moves the byte offset on
  assign port_hit = (reg_addr_i == `MCFG_ADDR_FEAT_PORT);
  // Two bytes to a word, so the word index is the offset halved
  assign widx     = 5'(off_r >> 1);
  // Low byte of a word at the even offset; past the table reads zero
  assign cur_byte = (widx < NW) ?
                    (off_r[0] ? word_r[widx][15:8] : word_r[widx][7:0])
                    : 8'h00;

  // ---------------------------------------------------------------
  // Host register access
  // ---------------------------------------------------------------
  // Next values of the host registers; a write wins over a read
  // issued in the same cycle
  always_comb begin
    init_nxt  = init_r;
    route_nxt = route_r;
    off_nxt   = off_r;
    start_nxt = 1'b0;
    rdata_nxt = rdata_r;
    for (int i = 0; i < NW; i++) begin
      word_nxt[i] = word_r[i];
    end
    // A burst start rewinds the offset; an access in that same cycle
    // still uses the old offset and moves it on
    if (burst_start_i) begin
      off_nxt = '0;
    end
    if (port_hit && (reg_wr_i || reg_rd_i)) begin
      off_nxt = off_r + 1'b1;
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `MCFG_ADDR_INIT_CTRL: begin
          init_nxt  = reg_wdata_i;
          start_nxt = 1'b1;
        end
        `MCFG_ADDR_PIN1_ROUTE: begin
          route_nxt = reg_wdata_i & 8'hee;
        end
        `MCFG_ADDR_FEAT_PORT: begin
          // Bytes past the table are dropped, the offset still moves
          if (widx < NW) begin
            if (off_r[0]) begin
              word_nxt[widx][15:8] = reg_wdata_i;
            end else begin
              word_nxt[widx][7:0] = reg_wdata_i;
            end
          end
        end
        default: begin
        end
      endcase
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `MCFG_ADDR_INIT_CTRL:  rdata_nxt = init_r;
        `MCFG_ADDR_PIN1_ROUTE: rdata_nxt = route_r;
        `MCFG_ADDR_FEAT_PORT: begin
          rdata_nxt = cur_byte;
        end
        default:               rdata_nxt = 8'h00;
      endcase
    end
  end

  // Register the host registers; every reset reloads the feature table,
  // so host settings are lost and must be written again afterwards
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      init_r  <= `MCFG_RST_INIT_CTRL;
      route_r <= `MCFG_RST_PIN1_ROUTE;
      off_r   <= '0;
      start_r <= 1'b0;
      rdata_r <= `MCFG_RST_FEAT_PORT;
      for (int i = 0; i < NW; i++) begin
        word_r[i] <= WORD_RST[i];
      end
    end else if (clk_en_i) begin
      init_r  <= init_nxt;
      route_r <= route_nxt;
      off_r   <= off_nxt;
      start_r <= start_nxt;
      rdata_r <= rdata_nxt;
      for (int i = 0; i < NW; i++) begin
        word_r[i] <= word_nxt[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // 50 Hz sample tick
  // ---------------------------------------------------------------
  logic [31:0] tick_r;
  logic [31:0] tick_nxt;
  logic        smp_stb;

  // One strobe every SAMPLE_CYC cycles; the enable stalls it as well
  assign smp_stb = (tick_r == 32'(SAMPLE_CYC - 1));

  always_comb begin
    tick_nxt = smp_stb ? 32'h0 : tick_r + 32'h1;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_r <= 32'h0;
    end else if (clk_en_i) begin
      tick_r <= tick_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Motion detector
  // ---------------------------------------------------------------
  // Settings are sliced straight from the two motion words, so a port
  // write takes effect on the following sample
  mcfg_motion_det #(
    .SW (11),
    .DW (13)
  ) u_det (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .clk_en_i   (clk_en_i),
    .thr_i      (word_r[0][`MCFG_THR_MSB:0]),
    .nomotion_i (word_r[0][`MCFG_BIT_NOMOTION]),
    .dur_i      (word_r[1][`MCFG_DUR_MSB:0]),
    .axis_en_i  (word_r[1][`MCFG_BIT_Z_EN:`MCFG_BIT_X_EN]),
    .smp_stb_i  (smp_stb),
    .slope_x_i  (slope_x_i),
    .slope_y_i  (slope_y_i),
    .slope_z_i  (slope_z_i),
    .motion_o   (motion_o)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Read data and the start pulse come straight from flip-flops
  assign reg_rdata_o  = rdata_r;
  assign init_start_o = start_r;
  assign int1_o = motion_o & route_r[`MCFG_BIT_ROUTE_MOTION];

  // Step parameter words out to the step counter; words 0 and 1 are the
  // motion settings, so the step words start at index 2
  for (genvar g = 0; g < 21; g++) begin : g_step
    assign step_param_o[g] = word_r[g + 2];
  end

endmodule : mcfg_feature_cfg

// >>> sim/mcfg_cfg_assertions.sv
// Checker for the feature configuration register bank.
// Assumes a bind onto mcfg_feature_cfg; sees its ports only.
`timescale 1ns/1ps
module mcfg_cfg_assertions (
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  input wire logic        clk_en_i,
  // Register port
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic [7:0]  reg_rdata_o,
  // Device outputs
  input wire logic        init_start_o,
  input wire logic        motion_o,
  input wire logic        int1_o,
  input wire logic [15:0] step_param_o [21]
);
  // Route bit 6 as last written by the host, tracked on its own
  logic route_seen;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      route_seen <= 1'b0;
    end else if (clk_en_i && reg_wr_i && reg_addr_i == 8'h56) begin
      route_seen <= reg_wdata_i[6];
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Write taken at the startup control register
  sequence s_init_wr;
    clk_en_i && reg_wr_i && reg_addr_i == 8'h59;
  endsequence
  // Read taken at an address with nothing behind it
  sequence s_void_rd;
    clk_en_i && reg_rd_i && !reg_wr_i && reg_addr_i == 8'h33;
  endsequence
  a_init_pulse: assert property (s_init_wr |=> init_start_o)
    else $error("start pulse missing after write");
  a_init_cause: assert property ($rose(init_start_o) |->
    $past(reg_wr_i) && $past(reg_addr_i) == 8'h59)
    else $error("start pulse without write");
  a_init_single: assert property (init_start_o && clk_en_i &&
    !(reg_wr_i && reg_addr_i == 8'h59) |=> !init_start_o)
    else $error("start pulse too long");
  a_void_read: assert property (s_void_rd |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  a_route_gate: assert property (int1_o == (motion_o && route_seen))
    else $error("pin one does not follow motion and route bit");
  a_route_drop: assert property ($fell(motion_o) |-> !int1_o)
    else $error("pin one outlived motion");
  a_motion_freeze: assert property (!clk_en_i |=> $stable(motion_o))
    else $error("motion moved while frozen");
  a_param_reset: assert property ($rose(rst_b_i) |->
    step_param_o[0] == 16'h012d && step_param_o[20] == 16'h0100)
    else $error("step defaults wrong");
endmodule : mcfg_cfg_assertions

// >>> sim/mcfg_host_model.sv
// Host processor model issuing byte register accesses.
// Assumes the bench clock; changes requests at falling edges.
`timescale 1ns/1ps
module mcfg_host_model (
  // Clock and read data
  input  wire logic       core_clk_i,
  input  wire logic [7:0] rdata_i,
  // Register requests
  output logic            wr_o,
  output logic            rd_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o,
  output logic            burst_o
);
  // Idle bus at time zero
  initial {wr_o, rd_o, addr_o, wdata_o, burst_o} = '0;
  // One write byte held across one taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge core_clk_i);
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask : wr
  // One read byte; data taken the cycle after
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge core_clk_i);
    rd_o = 1'b0;
    d = rdata_i;
  endtask : rd
  // Burst boundary pulse rewinds the port offset
  task automatic bst();
    @(negedge core_clk_i);
    burst_o = 1'b1;
    @(negedge core_clk_i);
    burst_o = 1'b0;
  endtask : bst
endmodule : mcfg_host_model

// >>> sim/mcfg_feature_cfg_bench.sv
// Self-checking bench for the feature configuration bank.
// Assumes the host model and checker; SAMPLE_CYC cut to 4.
`timescale 1ns/1ps
module mcfg_feature_cfg_bench;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic reg_wr_i, reg_rd_i, burst_start_i, init_start_o, motion_o, int1_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d, r;
  logic [10:0] slope_x_i = '0, slope_y_i = '0, slope_z_i = '0;
  logic [15:0] step_param_o [21];
  logic [15:0] exp [23] = '{16'h00aa, 16'h0005, 16'h012d, 16'h7bd4,
    16'h013b, 16'h7adb, 16'h0004, 16'h7b3f, 16'h6ccd, 16'h04c3, 16'h0985,
    16'h04c3, 16'he6ec, 16'h460c, 16'h0001, 16'h0027, 16'h0019, 16'h0096,
    16'h00a0, 16'h0001, 16'h000c, 16'h3cf0, 16'h0100};
  int error_cnt = 0;
  int comparisons = 0;
  // Clock at 200 MHz
  always #2.5 core_clk_i = ~core_clk_i;
  mcfg_host_model host (.core_clk_i(core_clk_i), .rdata_i(reg_rdata_o),
    .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i),
    .wdata_o(reg_wdata_i), .burst_o(burst_start_i));
  mcfg_feature_cfg #(.SAMPLE_CYC(4)) dut (.core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i), .clk_en_i(clk_en_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .burst_start_i(burst_start_i), .reg_rdata_o(reg_rdata_o),
    .slope_x_i(slope_x_i), .slope_y_i(slope_y_i), .slope_z_i(slope_z_i),
    .init_start_o(init_start_o), .motion_o(motion_o), .int1_o(int1_o),
    .step_param_o(step_param_o));
  // Compare one value and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  // Print counts and verdict, then stop
  task automatic wrap_up();
    $display("errors %0d of %0d checks", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  // Byte i of the feature table as the port presents it
  function automatic logic [7:0] port_byte(input int i);
    return exp[i/2][8*(i%2)+:8];
  endfunction : port_byte
  // Route register read-back: bits 4 and 0 are reserved and read zero
  function automatic logic [7:0] route_exp(input logic [7:0] v);
    return v & 8'hee;
  endfunction : route_exp
  // Walk all port bytes: write the table, or read and compare it
  task automatic burst(input bit wr);
    host.bst();
    for (int i = 0; i < 46; i++)
      if (wr) host.wr(8'h5e, port_byte(i));
      else begin
        host.rd(8'h5e, d);
        chk(16'(d), 16'(port_byte(i)));
      end
  endtask : burst
  // Bounded wait for the motion level
  task automatic wait_motion(input logic v);
    for (int n = 0; n < 40 && motion_o !== v; n++) @(negedge core_clk_i);
    chk(16'(motion_o), 16'(v));
  endtask : wait_motion
  // Main sequence
  initial begin
    void'($urandom(87139));
    repeat (20) @(posedge core_clk_i);
    @(negedge core_clk_i) rst_b_i = 1'b1;
    host.rd(8'h59, d);
    chk(16'(d), 16'h0090);
    host.rd(8'h56, d);
    chk(16'(d), 16'h0000);
    host.rd(8'h33, d);
    chk(16'(d), 16'h0000);
    host.wr(8'h59, 8'h00);
    chk(16'(init_start_o), 16'h0001);
    host.rd(8'h59, d);
    chk(16'(d), 16'h0000);
    burst(1'b0);
    exp[0] = 16'h0010;
    exp[1] = 16'h2002;
    for (int k = 2; k < 23; k++) exp[k] = 16'($urandom);
    burst(1'b1);
    for (int k = 0; k < 21; k++) chk(step_param_o[k], exp[k+2]);
    burst(1'b0);
    slope_x_i = 11'h011 + 11'($urandom_range(0, 1000));
    repeat (3) @(negedge core_clk_i);
    chk(16'(motion_o), 16'h0000);
    wait_motion(1'b1);
    chk(16'(int1_o), 16'h0000);
    host.wr(8'h56, 8'h40);
    chk(16'(int1_o), 16'h0001);
    slope_x_i = 11'h000;
    wait_motion(1'b0);
    host.bst();
    host.wr(8'h5e, 8'h10);
    host.wr(8'h5e, 8'h08);
    wait_motion(1'b1);
    // Enable low: slope over threshold, yet the event must stay frozen
    slope_x_i = 11'h7ff;
    clk_en_i = 1'b0;
    repeat (12) @(negedge core_clk_i);
    chk(16'(motion_o), 16'h0001);
    clk_en_i = 1'b1;
    wait_motion(1'b0);
    // Any-motion with only z enabled: x and y activity is ignored
    slope_y_i = 11'h7ff;
    host.bst();
    host.wr(8'h5e, 8'h10);
    host.wr(8'h5e, 8'h00);
    host.wr(8'h5e, 8'h02);
    host.wr(8'h5e, 8'h80);
    repeat (12) @(negedge core_clk_i);
    chk(16'(motion_o), 16'h0000);
    slope_z_i = 11'h011 + 11'($urandom_range(0, 1000));
    wait_motion(1'b1);
    // Random route value, read back with reserved bits cleared
    r = 8'($urandom) | 8'h40;
    host.wr(8'h56, r);
    host.rd(8'h56, d);
    chk(16'(d), 16'(route_exp(r)));
    chk(16'(int1_o), 16'h0001);
    wrap_up();
  end
endmodule : mcfg_feature_cfg_bench
bind mcfg_feature_cfg mcfg_cfg_assertions u_chk (.core_clk_i(core_clk_i),
  .rst_b_i(rst_b_i), .clk_en_i(clk_en_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o),
  .init_start_o(init_start_o), .motion_o(motion_o), .int1_o(int1_o),
  .step_param_o(step_param_o));
